// ---- core/gpio_pkg.sv ----
// Constants shared by the bidirectional port block and its per-port slices.
// What this block does
// - Direction bit 1 makes the pin an input; reads return the synchronised pin level.
// - Direction bit 0 drives the pin push-pull from its output latch.
// - Reading an output pin returns the latch contents, not the pad level.
// - Inputs pass a two-flop synchroniser; a port read captures the pin level sampled two clocks earlier.
// - Output data is latched and holds until software rewrites it.
// - Pull-high bit 1 connects weak pull-up on an input pin; 0 disconnects.
// - Port A pin seven has no pull-up; that pull-high bit is unimplemented.
// - Unimplemented direction, pull-high and wake bits read back as zero.
// - While halted, a falling edge on a wake-enabled Port A pin wakes the core.
// - Each Port A pin has its own wake enable; several may be enabled.
// - Direction bits may be rewritten anytime; the pin role follows at once.
// - Divider output reaches its pin only while that pin is an output.
// - PWM output drives its pin only while that pin is an output.
// - Reset sets all implemented data latch and direction bits high.
package gpio_pkg;

    localparam int NUM_PORTS = 6;
    localparam int PORT_W = 8;

    typedef logic [PORT_W-1:0] port_word_t;

    // Ports in order A, B, C, D, E, F.
    localparam port_word_t IMPL_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h7C, 8'hFF, 8'hFF, 8'h03};
    localparam port_word_t PU_MASK [NUM_PORTS] = '{8'h7F, 8'hFF, 8'h7C, 8'hFF, 8'hFF, 8'h03};
    localparam port_word_t DIR_RESET [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h7C, 8'hFF, 8'hFF, 8'h03};
    localparam port_word_t DATA_RESET = 8'hFF;
    localparam port_word_t PU_RESET = 8'h00;
    localparam port_word_t WAKE_RESET = 8'h00;

    // Data memory addresses of the port registers.
    localparam port_word_t DATA_ADDR [NUM_PORTS] = '{8'h12, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C};
    localparam port_word_t DIR_ADDR [NUM_PORTS] = '{8'h13, 8'h15, 8'h17, 8'h19, 8'h1B, 8'h1D};
    localparam port_word_t PU_ADDR [NUM_PORTS] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
    localparam port_word_t WAKE_ADDR = 8'h26;

    // Shared pin positions as port index and bit.
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int FREQ_DIV_BIT = 1;
    localparam int TIMER0_BIT = 2;
    localparam int IRQ_BIT = 3;
    localparam int TIMER1_BIT = 4;
    localparam int PWM0_BIT = 6;
    localparam int PWM1_BIT = 7;

endpackage : gpio_pkg

// ---- core/port_slice_if.sv ----
// Carrier between the port block and one port slice.
`timescale 1ns/1ps
`default_nettype none
interface port_slice_if;
    logic [7:0] wdata;
    logic we_data;
    logic we_dir;
    logic we_pu;
    logic [7:0] alt_en;
    logic [7:0] alt_val;
    logic [7:0] view;
    logic [7:0] dir;
    logic [7:0] pu;
    logic [7:0] level;

    modport owner (
        output wdata, we_data, we_dir, we_pu, alt_en, alt_val,
        input view, dir, pu, level
    );
    modport slice (
        input wdata, we_data, we_dir, we_pu, alt_en, alt_val,
        output view, dir, pu, level
    );
endinterface : port_slice_if
`default_nettype wire

// ---- core/port_slice.sv ----
// One 8-bit port: data latch, direction, pull-high and pad drive.
`timescale 1ns/1ps
`default_nettype none
module port_slice #(
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] PU_MASK = 8'hFF,
    parameter logic [7:0] DIR_RESET = 8'hFF
) (
    input wire logic clk,
    input wire logic rst,
    port_slice_if.slice bus,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup
);

    logic [7:0] latch_q, latch_d;
    logic [7:0] dir_q, dir_d;
    logic [7:0] pu_q, pu_d;
    logic [7:0] sync1_q, sync1_d;
    logic [7:0] sync2_q, sync2_d;
    logic [7:0] out_q, out_d;
    logic [7:0] oe_q, oe_d;
    logic [7:0] pull_q, pull_d;

    always_comb begin
        latch_d = bus.we_data ? (bus.wdata & IMPL_MASK) : latch_q;
        dir_d = bus.we_dir ? (bus.wdata & IMPL_MASK) : dir_q;
        pu_d = bus.we_pu ? (bus.wdata & PU_MASK) : pu_q;
        sync1_d = pad_in & IMPL_MASK;
        sync2_d = sync1_q;
        // Pad drive follows the next direction value so the role changes on the write edge.
        oe_d = ~dir_d & IMPL_MASK;
        // Shared outputs replace the latch only where the pin is an output.
        out_d = ((bus.alt_en & bus.alt_val) | (~bus.alt_en & latch_d)) & oe_d;
        pull_d = pu_d & dir_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= gpio_pkg::DATA_RESET & IMPL_MASK;
            dir_q <= DIR_RESET;
            pu_q <= gpio_pkg::PU_RESET;
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            out_q <= 8'h00;
            oe_q <= 8'h00;
            pull_q <= 8'h00;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            pu_q <= pu_d;
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            out_q <= out_d;
            oe_q <= oe_d;
            pull_q <= pull_d;
        end
    end

    // Input bits show the synchronised pin, output bits show the latch.
    assign bus.view = (dir_q & sync2_q) | (~dir_q & latch_q);
    assign bus.dir = dir_q;
    assign bus.pu = pu_q;
    assign bus.level = sync2_q;
    assign pad_out = out_q;
    assign pad_oe = oe_q;
    assign pad_pullup = pull_q;

endmodule : port_slice
`default_nettype wire

// ---- core/gpio_port_block.sv ----
// Six bidirectional ports with data memory access, shared pins and Port A wake-up.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_block (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata,
    input wire logic halted,
    output logic wake,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_in,
    output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_out,
    output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_oe,
    output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_pullup,
    input wire logic freq_divider_enable,
    input wire logic freq_divider_output,
    input wire logic pwm0_enable,
    input wire logic pwm0_value,
    input wire logic pwm1_enable,
    input wire logic pwm1_value,
    output logic ext_irq_level,
    output logic timer0_event_input,
    output logic timer1_event_input
);

    port_slice_if bus [gpio_pkg::NUM_PORTS] ();

    logic [gpio_pkg::NUM_PORTS-1:0][7:0] view_c;
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] dir_c;
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] pu_c;
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] alt_en_c;
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] alt_val_c;
    logic [gpio_pkg::NUM_PORTS-1:0] we_data_c;
    logic [gpio_pkg::NUM_PORTS-1:0] we_dir_c;
    logic [gpio_pkg::NUM_PORTS-1:0] we_pu_c;
    logic [7:0] pa_level;

    logic [7:0] wake_en_q, wake_en_d;
    logic [7:0] pa_prev_q, pa_prev_d;
    logic wake_q, wake_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] read_mux;

    // Address decode; each register has its own strobe.
    always_comb begin
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            we_data_c[p] = mem_wr && (mem_addr == gpio_pkg::DATA_ADDR[p]);
            we_dir_c[p] = mem_wr && (mem_addr == gpio_pkg::DIR_ADDR[p]);
            we_pu_c[p] = mem_wr && (mem_addr == gpio_pkg::PU_ADDR[p]);
        end
    end

    // Shared output functions; the slice gates them with the direction bit.
    always_comb begin
        alt_en_c = '0;
        alt_val_c = '0;
        alt_en_c[gpio_pkg::PORT_A][gpio_pkg::FREQ_DIV_BIT] = freq_divider_enable;
        alt_val_c[gpio_pkg::PORT_A][gpio_pkg::FREQ_DIV_BIT] = freq_divider_output;
        alt_en_c[gpio_pkg::PORT_B][gpio_pkg::PWM0_BIT] = pwm0_enable;
        alt_val_c[gpio_pkg::PORT_B][gpio_pkg::PWM0_BIT] = pwm0_value;
        alt_en_c[gpio_pkg::PORT_B][gpio_pkg::PWM1_BIT] = pwm1_enable;
        alt_val_c[gpio_pkg::PORT_B][gpio_pkg::PWM1_BIT] = pwm1_value;
    end

    genvar g;
    generate
        for (g = 0; g < gpio_pkg::NUM_PORTS; g++) begin : g_port
            assign bus[g].wdata = mem_wdata;
            assign bus[g].we_data = we_data_c[g];
            assign bus[g].we_dir = we_dir_c[g];
            assign bus[g].we_pu = we_pu_c[g];
            assign bus[g].alt_en = alt_en_c[g];
            assign bus[g].alt_val = alt_val_c[g];
            assign view_c[g] = bus[g].view;
            assign dir_c[g] = bus[g].dir;
            assign pu_c[g] = bus[g].pu;

            port_slice #(
                .IMPL_MASK(gpio_pkg::IMPL_MASK[g]),
                .PU_MASK(gpio_pkg::PU_MASK[g]),
                .DIR_RESET(gpio_pkg::DIR_RESET[g])
            ) u_slice (
                .clk(clk),
                .rst(rst),
                .bus(bus[g]),
                .pad_in(pin_in[g]),
                .pad_out(pin_out[g]),
                .pad_oe(pin_oe[g]),
                .pad_pullup(pin_pullup[g])
            );
        end
    endgenerate

    assign pa_level = bus[gpio_pkg::PORT_A].level;

    // The read mux is registered on the read strobe; input bits carry the pin level sampled two clocks earlier.
    always_comb begin
        read_mux = 8'h00;
        for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
            if (mem_addr == gpio_pkg::DATA_ADDR[p]) begin
                read_mux = view_c[p];
            end
            if (mem_addr == gpio_pkg::DIR_ADDR[p]) begin
                read_mux = dir_c[p];
            end
            if (mem_addr == gpio_pkg::PU_ADDR[p]) begin
                read_mux = pu_c[p];
            end
        end
        if (mem_addr == gpio_pkg::WAKE_ADDR) begin
            read_mux = wake_en_q;
        end
    end

    // Wake-up works only while this logic still sees clock edges; a sleep mode that stops
    // the clock needs the falling edge detected by an always-on clock source instead.
    always_comb begin
        wake_en_d = (mem_wr && mem_addr == gpio_pkg::WAKE_ADDR) ? mem_wdata : wake_en_q;
        pa_prev_d = pa_level;
        wake_d = halted && ((wake_en_q & pa_prev_q & ~pa_level) != 8'h00);
        rdata_d = mem_rd ? read_mux : rdata_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_en_q <= gpio_pkg::WAKE_RESET;
            pa_prev_q <= 8'h00;
            wake_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            wake_en_q <= wake_en_d;
            pa_prev_q <= pa_prev_d;
            wake_q <= wake_d;
            rdata_q <= rdata_d;
        end
    end

    assign mem_rdata = rdata_q;
    assign wake = wake_q;
    // Pin levels reach the interrupt and timers whatever the direction; software sets inputs.
    assign ext_irq_level = pa_level[gpio_pkg::IRQ_BIT];
    assign timer0_event_input = pa_level[gpio_pkg::TIMER0_BIT];
    assign timer1_event_input = pa_level[gpio_pkg::TIMER1_BIT];

endmodule : gpio_port_block
`default_nettype wire

// ---- tb/gpio_port_block_assertions.sv ----
// Concurrent checks on the port block's register bus and pad outputs.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic halted,
    input wire logic wake,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_out,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_oe,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_pullup
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_oe_follows_dir: assert property (mem_wr && mem_addr == 8'h13 |=> pin_oe[0] == ~$past(mem_wdata))
        else $error("port A drive enable does not follow the direction write");
    a_dir_read_back: assert property (mem_wr && mem_addr == 8'h13 ##1 !mem_wr ##1 mem_rd && mem_addr == 8'h13
        |=> mem_rdata == $past(mem_wdata, 3)) else $error("direction read back differs from written value");
    a_pullup_input_only: assert property ((pin_pullup & pin_oe) == '0)
        else $error("pull-up enabled on a driven pin");
    a_pin_seven_bare: assert property (!pin_pullup[0][7])
        else $error("port A pin seven shows a pull-up");
    a_unimpl_reads_zero: assert property (mem_rd && mem_addr == 8'h20 |=> !mem_rdata[7])
        else $error("missing pull-up bit reads as one");
    a_undriven_low: assert property ((pin_out & ~pin_oe) == '0)
        else $error("drive value present on a pin set as input");
    a_latch_holds: assert property (!(mem_wr && (mem_addr == 8'h16 || mem_addr == 8'h17)) |=> $stable(pin_out[2]))
        else $error("port C output changed without a write");
    a_wake_when_halted: assert property (wake |-> $past(halted))
        else $error("wake raised while the core was running");
endmodule : gpio_port_checker
bind gpio_port_block gpio_port_checker u_chk (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .halted(halted), .wake(wake), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup));
`default_nettype wire

// ---- tb/ext_switches.sv ----
// Model of the switches and circuitry wired to the port pads.
`timescale 1ns/1ps
`default_nettype none
module ext_switches (
    input wire logic clk,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_out,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_oe,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_pullup,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] sw_val,
    input wire logic [gpio_pkg::NUM_PORTS-1:0][7:0] sw_en,
    output logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_in
);
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] float_q = '0;
    // A floating pad toggles every cycle so that a lost pull-up never reads as a lucky constant.
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Device drive wins, then a closed switch holding its level, then the weak pull-up.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & sw_en & sw_val)
        | (~pin_oe & ~sw_en & (pin_pullup | float_q));
endmodule : ext_switches
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the bidirectional port block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rst, mem_wr, mem_rd, halted, wake, fd_en, fd_val, p0_en, p0_val, p1_en, p1_val, irq, t0, t1, seen;
    logic [7:0] mem_addr, mem_wdata, mem_rdata;
    logic [gpio_pkg::NUM_PORTS-1:0][7:0] pin_in, pin_out, pin_oe, pin_pullup, sw_val, sw_en;
    int errors, checks_done;
    localparam logic [7:0] DIR_POR [6] = '{8'hFF, 8'hFF, 8'h7C, 8'hFF, 8'hFF, 8'h03};
    localparam logic [7:0] PU_ALL [6] = '{8'h7F, 8'hFF, 8'h7C, 8'hFF, 8'hFF, 8'h03};
    gpio_port_block uut (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .halted(halted), .wake(wake), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .freq_divider_enable(fd_en), .freq_divider_output(fd_val),
        .pwm0_enable(p0_en), .pwm0_value(p0_val), .pwm1_enable(p1_en), .pwm1_value(p1_val),
        .ext_irq_level(irq), .timer0_event_input(t0), .timer1_event_input(t1));
    ext_switches sw (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .sw_val(sw_val),
        .sw_en(sw_en), .pin_in(pin_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        mem_wr <= 1'b1;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_wr <= 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        mem_rd <= 1'b1;
        mem_addr <= a;
        @(posedge clk);
        mem_rd <= 1'b0;
        @(negedge clk);
        check(mem_rdata, exp);
    endtask : rdc
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic wake_seen(input logic exp);
        seen = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (wake === 1'b1) seen = 1'b1;
        end
        check({7'h00, seen}, {7'h00, exp});
    endtask : wake_seen
    task automatic results();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    // The tests need well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        results();
    end
    initial begin
        {errors, checks_done} = '0;
        {rst, mem_wr, mem_rd, halted, fd_en, fd_val, p0_en, p0_val, p1_en, p1_val} = 10'h200;
        {mem_addr, mem_wdata} = '0;
        sw_en = '1;
        sw_val = '1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(gpio_pkg::DIR_ADDR[i], DIR_POR[i]);
        rdc(gpio_pkg::WAKE_ADDR, 8'h00);
        wr(8'h30, 8'hFF);
        rdc(8'h30, 8'h00);
        wr(gpio_pkg::DIR_ADDR[2], 8'h00);
        check(pin_out[2], 8'h7C);
        for (int i = 0; i < 6; i++) begin
            wr(gpio_pkg::PU_ADDR[i], 8'hFF);
            rdc(gpio_pkg::PU_ADDR[i], PU_ALL[i]);
        end
        check(pin_pullup[0], 8'h7F);
        sw_val[1] <= 8'hA5;
        settle();
        rdc(8'h14, 8'hA5);
        wr(8'h14, 8'h3C);
        wr(8'h15, 8'h0F);
        check(pin_oe[1], 8'hF0);
        check(pin_out[1], 8'h30);
        check(pin_pullup[1], 8'h0F);
        rdc(8'h14, 8'h35);
        sw_val[1] <= 8'h5A;
        settle();
        rdc(8'h14, 8'h3A);
        wr(8'h15, 8'hFF);
        check(pin_oe[1], 8'h00);
        wr(8'h15, 8'h00);
        {p0_en, p0_val, p1_en, p1_val} <= 4'hE;
        settle();
        check(pin_out[1], 8'h7C);
        wr(8'h15, 8'hC0);
        check(pin_out[1], 8'h3C);
        {fd_en, fd_val} <= 2'h3;
        settle();
        check(pin_out[0], 8'h00);
        wr(8'h13, 8'hFD);
        rdc(8'h13, 8'hFD);
        check(pin_out[0], 8'h02);
        sw_val[0] <= 8'h14;
        settle();
        check({5'h00, irq, t0, t1}, 8'h03);
        rdc(8'h12, 8'h16);
        wr(gpio_pkg::WAKE_ADDR, 8'h11);
        rdc(gpio_pkg::WAKE_ADDR, 8'h11);
        sw_val[0] <= 8'h15;
        settle();
        halted <= 1'b1;
        settle();
        sw_val[0] <= 8'h14;
        wake_seen(1'b1);
        sw_val[0] <= 8'h10;
        wake_seen(1'b0);
        halted <= 1'b0;
        sw_val[0] <= 8'h00;
        wake_seen(1'b0);
        // A second reset in mid-run must restore the port B latch that was written with 3C.
        {rst, p0_en, p1_en} <= 3'h4;
        settle();
        rst <= 1'b0;
        rdc(8'h13, 8'hFF);
        wr(8'h15, 8'h0F);
        check(pin_out[1], 8'hF0);
        rdc(8'h14, 8'hFA);
        wr(8'h14, 8'h7A);
        check(pin_out[1], 8'h70);
        results();
    end
endmodule : tb_top
`default_nettype wire
